// [rtl/abs_turns_pkg.sv]
/*
  Constants, character codes and state type for the absolute turns report.
  Assumes a single 25 MHz clock shared by every design file.
*/
// Summary of operation
// - Serial line sends 9600 baud characters: start, 7 ASCII bits, even parity, stop.
// - A turns frame is P, sign, five decimal digits, carriage return.
// - With default limit the count spans -32768 to +32767 and wraps.
// - Initial incremental pulses go through the same divider as normal ones.
// - Sensor-off with absolute encoder sends the alarm contents serially.
// - Sensor-off is refused while motor power is on.
// - Reverse turn at count 0 loads the turn limit.
// - Forward turn at the turn limit returns the count to 0.
// - Turn limit 0 to 65535, default 65535, taken only at restart.
// - Drive and encoder limits differing raises the mismatch alarm, alarm output high.
// - Origin offset within +/-1073741823, default 0, applied after sensor-on.
// - Machine position is encoder position minus origin offset.
// - 100 ms after sensor-on clear up/down count; normal 400 ms after frame.
`default_nettype none
package abs_turns_pkg;
  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_HZ = 25_000_000;
  localparam int BAUD_BPS = 9600;
  localparam int BIT_CYCLES = CLK_HZ / BAUD_BPS;
  localparam int ON_DELAY_MS = 100;
  localparam int SETTLE_MS = 400;
  localparam int ON_DELAY_CYCLES = (CLK_HZ / 1000) * ON_DELAY_MS;
  localparam int SETTLE_CYCLES = (CLK_HZ / 1000) * SETTLE_MS;

  // ***************************************************************
  // Settings and frame layout
  // ***************************************************************
  localparam logic [15:0] TURN_LIMIT_RESET = 16'hFFFF;
  localparam logic signed [31:0] OFFSET_MAX = 32'sh3FFFFFFF;
  localparam logic signed [31:0] OFFSET_RESET = 32'sh00000000;
  localparam logic [15:0] ALARM_TURN_LIMIT = 16'h0001; // Arbitrary code
  localparam int FRAME_LEN = 8;
  localparam int DIGITS = 5;
  localparam int CHAR_BITS = 7;
  localparam logic [6:0] CHAR_P = 7'h50;
  localparam logic [6:0] CHAR_PLUS = 7'h2B;
  localparam logic [6:0] CHAR_MINUS = 7'h2D;
  localparam logic [6:0] CHAR_CR = 7'h0D;
  localparam logic [6:0] CHAR_ZERO = 7'h30;
  localparam logic [6:0] CHAR_LETTER_A = 7'h41;
  localparam logic [6:0] CHAR_LETTER_L = 7'h4C;
  localparam logic [6:0] CHAR_LETTER_M = 7'h4D;
  localparam logic [6:0] CHAR_HEX_ALPHA = 7'h37;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT_ON = 3'b001,
    ST_BUILD = 3'b010,
    ST_LOAD = 3'b011,
    ST_DRAIN = 3'b100,
    ST_SETTLE = 3'b101,
    ST_NORMAL = 3'b110
  } report_state_t;
endpackage
`default_nettype wire

// [rtl/char_fifo.sv]
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock; the drain side may stall for any time.
*/
`default_nettype none
module char_fifo #(
  parameter int WIDTH = 7,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// [rtl/char_serializer.sv]
/*
  Start-stop character sender: start, 7 data bits LSB first, even parity, stop.
  Assumes the character source holds data while valid and not ready.
*/
`default_nettype none
module char_serializer
  import abs_turns_pkg::*;
#(
  parameter int BIT_TIME = BIT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Character in
  input wire logic char_valid,
  input wire logic [CHAR_BITS-1:0] char_data,
  output logic char_ready,
  // Line
  output logic line_out,
  output logic busy
);
  logic [9:0] shift;
  logic [3:0] bits_left;
  logic [11:0] baud_cnt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift <= 10'h3FF;
      bits_left <= 4'h0;
      baud_cnt <= 12'h000;
      busy <= 1'b0;
      char_ready <= 1'b0;
      line_out <= 1'b1;
    end else if (!busy) begin
      line_out <= 1'b1;
      char_ready <= 1'b1;
      if (char_valid && char_ready) begin
        // Frame: stop, even parity, data, start
        shift <= {1'b1, ^char_data, char_data, 1'b0};
        bits_left <= 4'hA;
        baud_cnt <= 12'h000;
        busy <= 1'b1;
        char_ready <= 1'b0;
      end
    end else if (baud_cnt == 12'h000) begin
      if (bits_left == 4'h0) begin
        busy <= 1'b0;
        line_out <= 1'b1;
      end else begin
        line_out <= shift[0];
        shift <= {1'b1, shift[9:1]};
        bits_left <= bits_left - 1'b1;
        // Bit times above 4096 cycles need a wider counter
        baud_cnt <= 12'(BIT_TIME - 1);
      end
    end else begin
      baud_cnt <= baud_cnt - 1'b1;
    end
  end
endmodule
`default_nettype wire

// [rtl/abs_turns_report.sv]
/*
  Absolute turns report: multiturn counter, serial frame sender on the
  serial position line, pulse divider, turn limit check and origin offset.
  Assumes all inputs are synchronous to clk and step strobes are one cycle.
*/
`default_nettype none
module abs_turns_report
  import abs_turns_pkg::*;
#(
  parameter int ON_DELAY = ON_DELAY_CYCLES,
  parameter int SETTLE_DELAY = SETTLE_CYCLES,
  parameter int BIT_TIME = BIT_CYCLES,
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Drive status and host commands
  input wire logic encoder_fitted,
  input wire logic motor_power_on,
  input wire logic sensor_on_command,
  input wire logic sensor_off_command,
  input wire logic [15:0] alarm_contents,
  // Encoder side
  input wire logic turn_step_fwd,
  input wire logic turn_step_rev,
  input wire logic [15:0] encoder_turn_limit,
  input wire logic signed [31:0] encoder_position,
  input wire logic inc_pulse,
  input wire logic inc_dir,
  input wire logic initial_pulse,
  input wire logic initial_dir,
  // Settings
  input wire logic [15:0] turn_limit_setting,
  input wire logic signed [31:0] origin_offset_setting,
  input wire logic [15:0] pulse_divide_ratio,
  // Outputs
  output logic serial_position_out,
  output logic divided_pulse,
  output logic divided_dir,
  output logic [15:0] updown_count,
  output logic [15:0] turn_count,
  output logic servo_alarm_open,
  output logic turn_limit_mismatch_alarm,
  output logic signed [31:0] machine_coordinate_position
);
  report_state_t state;
  logic [15:0] turn_limit;
  logic limit_taken;
  logic signed [31:0] origin_offset;
  logic offset_enabled;
  logic alarm_mode;
  logic [CHAR_BITS-1:0] frame [FRAME_LEN];
  logic [2:0] idx;
  logic [16:0] remain;
  logic [3:0] digit;
  logic [23:0] timer;
  logic [15:0] div_cnt;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [CHAR_BITS-1:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [CHAR_BITS-1:0] fifo_out_data;
  logic tx_busy;
  logic tx_line;
  logic off_accept;
  logic on_accept;
  logic signed_view;
  logic [16:0] magnitude;
  logic src_pulse;
  logic src_dir;

  function automatic logic [16:0] pow10(input logic [2:0] k);
    case (k)
      3'h0: pow10 = 17'h02710;
      3'h1: pow10 = 17'h003E8;
      3'h2: pow10 = 17'h00064;
      3'h3: pow10 = 17'h0000A;
      default: pow10 = 17'h00001;
    endcase
  endfunction

  function automatic logic [6:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'hA) ? CHAR_ZERO + 7'(n) : CHAR_HEX_ALPHA + 7'(n);
  endfunction

  // ***************************************************************
  // Commands
  // ***************************************************************
  // Power on blocks sensor-off entirely; the host must retry later
  assign off_accept = sensor_off_command && encoder_fitted && !motor_power_on
    && (state == ST_IDLE || state == ST_NORMAL);
  assign on_accept = sensor_on_command && encoder_fitted && !off_accept
    && (state == ST_IDLE);
  assign signed_view = (turn_limit == TURN_LIMIT_RESET);
  assign magnitude = (signed_view && turn_count[15]) ?
    17'h10000 - {1'b0, turn_count} : {1'b0, turn_count};

  // ***************************************************************
  // Turn limit, taken once after restart
  // ***************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      turn_limit <= TURN_LIMIT_RESET;
      limit_taken <= 1'b0;
    end else if (!limit_taken) begin
      turn_limit <= turn_limit_setting;
      limit_taken <= 1'b1;
    end
  end

  // ***************************************************************
  // Multiturn counter
  // ***************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      turn_count <= 16'h0000;
    end else if (turn_step_fwd && !turn_step_rev) begin
      turn_count <= (turn_count == turn_limit) ? 16'h0000
        : turn_count + 1'b1;
    end else if (turn_step_rev && !turn_step_fwd) begin
      turn_count <= (turn_count == 16'h0000) ? turn_limit
        : turn_count - 1'b1;
    end
  end

  // ***************************************************************
  // Limit mismatch alarm
  // ***************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      turn_limit_mismatch_alarm <= 1'b0;
      servo_alarm_open <= 1'b0;
    end else begin
      // Held off until the limit is latched, or reset would flash the alarm
      turn_limit_mismatch_alarm <= encoder_fitted && limit_taken
        && (turn_limit != encoder_turn_limit);
      servo_alarm_open <= encoder_fitted && limit_taken
        && (turn_limit != encoder_turn_limit);
    end
  end

  // ***************************************************************
  // Origin offset and machine coordinate
  // ***************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      origin_offset <= OFFSET_RESET;
      offset_enabled <= 1'b0;
      machine_coordinate_position <= 32'sh00000000;
    end else begin
      // Out-of-range settings are ignored, the last good value stays
      if (origin_offset_setting <= OFFSET_MAX
          && origin_offset_setting >= -OFFSET_MAX) begin
        origin_offset <= origin_offset_setting;
      end
      if (off_accept) begin
        offset_enabled <= 1'b0;
      end else if (on_accept) begin
        offset_enabled <= 1'b1;
      end
      machine_coordinate_position <= offset_enabled ?
        encoder_position - origin_offset : encoder_position;
    end
  end

  // ***************************************************************
  // Sequencer and frame builder
  // ***************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      alarm_mode <= 1'b0;
      idx <= 3'h0;
      remain <= 17'h00000;
      digit <= 4'h0;
      timer <= 24'h000000;
      for (int i = 0; i < FRAME_LEN; i++) begin
        frame[i] <= CHAR_CR;
      end
    end else begin
      case (state)
        ST_IDLE, ST_NORMAL: begin
          if (off_accept) begin
            // Alarm frame: A L M, four hex digits, CR
            alarm_mode <= 1'b1;
            frame[0] <= CHAR_LETTER_A;
            frame[1] <= CHAR_LETTER_L;
            frame[2] <= CHAR_LETTER_M;
            for (int i = 0; i < 4; i++) begin
              frame[3+i] <= hex_char(turn_limit_mismatch_alarm ?
                ALARM_TURN_LIMIT[15-4*i -: 4] : alarm_contents[15-4*i -: 4]);
            end
            frame[7] <= CHAR_CR;
            idx <= 3'h0;
            state <= ST_LOAD;
          end else if (on_accept) begin
            alarm_mode <= 1'b0;
            timer <= 24'(ON_DELAY - 1);
            state <= ST_WAIT_ON;
          end
        end
        ST_WAIT_ON: begin
          if (timer == 24'h000000) begin
            frame[0] <= CHAR_P;
            frame[1] <= (signed_view && turn_count[15]) ? CHAR_MINUS
              : CHAR_PLUS;
            frame[7] <= CHAR_CR;
            remain <= magnitude;
            digit <= 4'h0;
            idx <= 3'h0;
            state <= ST_BUILD;
          end else begin
            timer <= timer - 1'b1;
          end
        end
        ST_BUILD: begin
          // Repeated subtraction: slow but needs no divider
          if (remain >= pow10(idx)) begin
            remain <= remain - pow10(idx);
            digit <= digit + 1'b1;
          end else begin
            frame[2+idx] <= CHAR_ZERO + 7'(digit);
            digit <= 4'h0;
            idx <= (idx == 3'(DIGITS - 1)) ? 3'h0 : idx + 1'b1;
            if (idx == 3'(DIGITS - 1)) begin
              state <= ST_LOAD;
            end
          end
        end
        ST_LOAD: begin
          if (fifo_in_ready) begin
            idx <= idx + 1'b1;
            if (idx == 3'(FRAME_LEN - 1)) begin
              state <= ST_DRAIN;
            end
          end
        end
        ST_DRAIN: begin
          if (!fifo_out_valid && !tx_busy) begin
            timer <= 24'(SETTLE_DELAY - 1);
            state <= alarm_mode ? ST_IDLE : ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (timer == 24'h000000) begin
            state <= ST_NORMAL;
          end else begin
            timer <= timer - 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  assign fifo_in_valid = (state == ST_LOAD);
  assign fifo_in_data = frame[idx];

  // ***************************************************************
  // Character path
  // ***************************************************************
  char_fifo #(.WIDTH(CHAR_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(fifo_in_valid),
    .in_data(fifo_in_data),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(fifo_out_ready)
  );

  char_serializer #(.BIT_TIME(BIT_TIME)) u_ser (
    .clk(clk),
    .rst_n(rst_n),
    .char_valid(fifo_out_valid),
    .char_data(fifo_out_data),
    .char_ready(fifo_out_ready),
    .line_out(tx_line),
    .busy(tx_busy)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_position_out <= 1'b1;
    end else begin
      serial_position_out <= tx_line;
    end
  end

  // ***************************************************************
  // Pulse divider and up/down count
  // ***************************************************************
  // Initial pulses share the divider so the host sees one scaling
  assign src_pulse = (state == ST_SETTLE) ? initial_pulse
    : (state == ST_NORMAL) && inc_pulse;
  assign src_dir = (state == ST_SETTLE) ? initial_dir : inc_dir;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 16'h0000;
      divided_pulse <= 1'b0;
      divided_dir <= 1'b0;
    end else begin
      divided_pulse <= 1'b0;
      if (src_pulse) begin
        divided_dir <= src_dir;
        if (div_cnt + 1'b1 >= pulse_divide_ratio) begin
          div_cnt <= 16'h0000;
          divided_pulse <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      updown_count <= 16'h0000;
    end else if (state == ST_WAIT_ON && timer == 24'h000000) begin
      updown_count <= 16'h0000;
    end else if (divided_pulse) begin
      updown_count <= divided_dir ? updown_count - 1'b1
        : updown_count + 1'b1;
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_fwd_wrap_zero: assert property (
    turn_step_fwd && !turn_step_rev && turn_count == turn_limit
    |=> turn_count == 16'h0000)
    else $error("forward step at limit did not clear count");
  a_rev_load_limit: assert property (
    turn_step_rev && !turn_step_fwd && turn_count == 16'h0000
    |=> turn_count == $past(turn_limit))
    else $error("reverse step at zero did not load limit");
  a_default_span_wrap: assert property (
    turn_limit == 16'hFFFF && turn_step_fwd && !turn_step_rev
    && turn_count == 16'h7FFF |=> turn_count == 16'h8000 && magnitude
    == 17'h08000)
    else $error("default span did not wrap to -32768");
  a_mismatch_alarm: assert property (
    rst_n && limit_taken && encoder_fitted
    && turn_limit != encoder_turn_limit
    |=> servo_alarm_open && turn_limit_mismatch_alarm)
    else $error("limit mismatch not flagged");
  a_off_refused: assert property (
    state == ST_IDLE && sensor_off_command && motor_power_on
    && !sensor_on_command |=> state == ST_IDLE && $stable(alarm_mode))
    else $error("sensor-off accepted under motor power");
  a_line_mark_idle: assert property (
    state == ST_IDLE && $past(state) == ST_IDLE |-> serial_position_out)
    else $error("serial line not at mark while idle");
  a_no_offset_before: assert property (
    rst_n && !offset_enabled |=> machine_coordinate_position
    == $past(encoder_position))
    else $error("offset applied before sensor-on");
  a_offset_origin: assert property (
    offset_enabled && encoder_position == origin_offset
    |=> machine_coordinate_position == 32'sh00000000)
    else $error("encoder at offset is not origin");
  a_frame_head_p: assert property (
    state == ST_LOAD && idx == 3'h0 && !alarm_mode
    |-> fifo_in_data == CHAR_P)
    else $error("turns frame does not begin with P");
  a_count_cleared: assert property (
    state == ST_WAIT_ON ##1 state == ST_BUILD |-> updown_count == 16'h0000)
    else $error("up/down count not cleared after delay");
  a_start_bit_low: assert property (
    $rose(tx_busy) |-> ##2 !serial_position_out [*8])
    else $error("start bit not driven low");

  c_turns_frame: cover property (state == ST_DRAIN ##1 state == ST_SETTLE);
  c_alarm_frame: cover property (alarm_mode && state == ST_DRAIN
    ##1 state == ST_IDLE);
  c_rev_wrap: cover property (turn_step_rev && turn_count == 16'h0000);
  c_fifo_full: cover property (state == ST_LOAD && !fifo_in_ready);
endmodule
`default_nettype wire

// [sim/host_rx_model.sv]
/*
  Host receiver model: decodes start-stop characters from the serial line.
  Assumes the line rests at mark and one bit lasts BIT_TIME clocks.
*/
`default_nettype none
module host_rx_model
  import abs_turns_pkg::*;
#(
  parameter int BIT_TIME = BIT_CYCLES
) (
  // Clock and line
  input wire logic clk,
  input wire logic line,
  // Decoded character
  output logic rx_valid,
  output logic [CHAR_BITS-1:0] rx_char,
  output logic rx_err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  // ***************************************************************
  // Receiver
  // ***************************************************************
  initial begin
    rx_valid = 1'b0;
    rx_char = '0;
    rx_err = 1'b0;
    forever begin
      @(negedge line);
      // Sample mid-bit, so a one-cycle launch skew does no harm
      repeat (BIT_TIME / 2) @(posedge clk);
      if (line !== 1'b0) rx_err = 1'b1;
      // Seven data bits, then the parity bit
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_TIME) @(posedge clk);
        sh[i] = line;
      end
      repeat (BIT_TIME) @(posedge clk);
      if (line !== 1'b1 || ^sh !== 1'b0) rx_err = 1'b1;
      rx_char = sh[6:0];
      rx_valid = 1'b1;
      @(posedge clk);
      rx_valid = 1'b0;
    end
  end
endmodule
`default_nettype wire

// [sim/tb.sv]
/*
  Testbench for the absolute turns report: counter, limits, frames.
  Assumes shortened sensor-on, settle and bit times.
*/
`default_nettype none
module tb
  import abs_turns_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ON_D = 20;
  localparam int SET_D = 40;
  localparam int BIT_T = 20;
  localparam int LIMIT = 20000;
  logic clk, rst_n, fitted, pwr, s_on, s_off, fwd, rev, ipulse, idir;
  logic inc, dir, line, dpulse, ddir, alm_open, mism, rx_valid, rx_err;
  logic [15:0] alarms, enc_lim, lim_set, ratio, updown, turns;
  logic signed [31:0] enc_pos, offset, mpos;
  logic [6:0] rx_char;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;

  abs_turns_report #(.ON_DELAY(ON_D), .SETTLE_DELAY(SET_D),
    .FIFO_DEPTH(4), .BIT_TIME(BIT_T)) dut (.clk(clk), .rst_n(rst_n),
    .encoder_fitted(fitted), .motor_power_on(pwr),
    .sensor_on_command(s_on), .sensor_off_command(s_off),
    .alarm_contents(alarms), .turn_step_fwd(fwd), .turn_step_rev(rev),
    .encoder_turn_limit(enc_lim), .encoder_position(enc_pos),
    .inc_pulse(inc), .inc_dir(dir), .initial_pulse(ipulse),
    .initial_dir(idir), .turn_limit_setting(lim_set),
    .origin_offset_setting(offset), .pulse_divide_ratio(ratio),
    .serial_position_out(line), .divided_pulse(dpulse),
    .divided_dir(ddir), .updown_count(updown), .turn_count(turns),
    .servo_alarm_open(alm_open), .turn_limit_mismatch_alarm(mism),
    .machine_coordinate_position(mpos));
  host_rx_model #(.BIT_TIME(BIT_T)) rx (.clk(clk), .line(line),
    .rx_valid(rx_valid), .rx_char(rx_char), .rx_err(rx_err));

  always #20 clk = ~clk;
  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Caps the whole run at LIMIT cycles and counts reaching it as a failure
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_fail++;
      summarize();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic do_reset(input logic [15:0] lim);
    @(posedge clk);
    rst_n <= 1'b0;
    lim_set <= lim;
    enc_lim <= lim;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  task automatic step(input logic f, input logic [15:0] exp);
    @(posedge clk);
    fwd <= f;
    rev <= ~f;
    @(posedge clk);
    fwd <= 1'b0;
    rev <= 1'b0;
    @(negedge clk);
    chk("turns", 32'(turns), 32'(exp));
  endtask
  task automatic get_frame(input string s);
    int w;
    for (int i = 0; i < FRAME_LEN; i++) begin
      w = 0;
      do begin
        @(negedge clk);
        w++;
      end while (rx_valid !== 1'b1 && w < 20 * BIT_T);
      chk("rx_valid", 32'(rx_valid), 32'h1);
      chk("char", 32'(rx_char), 32'(s[i]));
    end
    chk("line_err", 32'(rx_err), 32'h0);
  endtask
  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic t_limits();
    do_reset(16'hFFFF);
    @(negedge clk);
    chk("idle", 32'(line), 32'h1);
    chk("turns0", 32'(turns), 32'h0);
    step(1'b0, 16'hFFFF);
    step(1'b1, 16'h0000);
    do_reset(16'd99);
    lim_set <= 16'd5;
    step(1'b0, 16'd99);
    step(1'b1, 16'd0);
    @(posedge clk);
    enc_lim <= 16'd98;
    repeat (3) @(negedge clk);
    chk("mism", 32'(mism), 32'h1);
    chk("alm_open", 32'(alm_open), 32'h1);
    @(posedge clk);
    s_off <= 1'b1;
    @(posedge clk);
    s_off <= 1'b0;
    get_frame("ALM0001\r");
    @(posedge clk);
    enc_lim <= 16'd99;
    repeat (3) @(negedge clk);
    chk("mism_off", 32'(mism), 32'h0);
    $display("limits done");
  endtask
  task automatic t_frame();
    do_reset(16'hFFFF);
    step(1'b0, 16'hFFFF);
    step(1'b0, 16'hFFFE);
    step(1'b0, 16'hFFFD);
    @(posedge clk);
    pwr <= 1'b1;
    s_off <= 1'b1;
    @(posedge clk);
    s_off <= 1'b0;
    repeat (20) @(negedge clk);
    chk("refused", 32'(line), 32'h1);
    chk("mpos_pre", mpos, 32'sd1000);
    @(posedge clk);
    s_on <= 1'b1;
    @(posedge clk);
    s_on <= 1'b0;
    repeat (ON_D - 4) @(negedge clk);
    chk("wait_on", 32'(line), 32'h1);
    repeat (8) @(negedge clk);
    chk("updown0", 32'(updown), 32'h0);
    chk("mpos_on", mpos, 32'sd0);
    get_frame("P-00003\r");
    // Rest of the last stop bit, then the settle window opens
    repeat (BIT_T / 2 + 4) @(posedge clk);
    repeat (4) begin
      ipulse <= 1'b1;
      @(posedge clk);
      ipulse <= 1'b0;
      @(posedge clk);
    end
    repeat (SET_D + 20) @(posedge clk);
    repeat (2) begin
      inc <= 1'b1;
      @(posedge clk);
      inc <= 1'b0;
      @(posedge clk);
    end
    @(negedge clk);
    chk("updown", 32'(updown), 32'h3);
    chk("ddir", 32'(ddir), 32'h0);
    chk("dpulse", 32'(dpulse), 32'h0);
    $display("frame done");
  endtask
  task automatic t_alarm();
    @(posedge clk);
    pwr <= 1'b0;
    alarms <= 16'hA5C3;
    s_off <= 1'b1;
    @(posedge clk);
    s_off <= 1'b0;
    get_frame("ALMA5C3\r");
    chk("mpos_off", mpos, 32'sd1000);
    // Let the alarm frame drain so the block is idle again
    repeat (BIT_T) @(posedge clk);
    s_on <= 1'b1;
    @(posedge clk);
    s_on <= 1'b0;
    repeat (ON_D + 2) @(negedge clk);
    chk("updown_clr", 32'(updown), 32'h0);
    chk("mpos_on2", mpos, 32'sd0);
    $display("alarm done");
  endtask
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {fitted, pwr, s_on, s_off, fwd, rev, ipulse, idir, inc, dir} = '0;
    fitted = 1'b1;
    alarms = 16'h0000;
    ratio = 16'h0002;
    enc_pos = 32'sd1000;
    offset = 32'sd1000;
    lim_set = 16'hFFFF;
    enc_lim = 16'hFFFF;
    t_limits();
    t_frame();
    t_alarm();
    summarize();
  end
endmodule
`default_nettype wire
